/* File: common/fpm_pkg.sv */
// Constants for the front-panel mode control block.
// Assumes a 50 MHz system clock and a 32-bit word register port.
package fpm_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int STARTUP_MS = 3000;
  localparam int STARTUP_CYC = STARTUP_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 28;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ERROR = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_LINK_CTRL = 8'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ST_LOCAL_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_CMD_BUSY_BIT = 3;
  localparam int ST_ADDR_LSB = 4;
  localparam int CMD_GO_BIT = 7;
  localparam int ERR_W = 4;
  localparam int IRQ_W = 5;
  localparam int IRQ_LOCAL = 0;
  localparam int IRQ_REMOTE = 1;
  localparam int IRQ_ERROR = 2;
  localparam int IRQ_READY = 3;
  localparam int IRQ_REFUSED = 4;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [ERR_W-1:0] ERR_RST = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
  localparam logic [3:0] ADDR_RST = 4'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    FPM_ST_HOLD = 2'b00,
    FPM_ST_STARTUP = 2'b01,
    FPM_ST_RUN = 2'b10
  } fpm_state_t;

  typedef enum logic [2:0] {
    FPM_CMD_NONE = 3'b000,
    FPM_CMD_DOWNLOAD = 3'b001,
    FPM_CMD_UPLOAD = 3'b010,
    FPM_CMD_SINGLE = 3'b011,
    FPM_CMD_TEST_RUN = 3'b100
  } fpm_cmd_t;

endpackage

/* File: verilog/fpm_debounce.sv */
// Two-flop synchroniser followed by a stability filter.
// Assumes the raw input is an asynchronous switch contact.
`timescale 1ns/1ps
module fpm_debounce #(
  parameter int STABLE_CYC = fpm_pkg::DEBOUNCE_CYC
) (
  input wire logic mclk_i,  // System clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic raw_i,   // Raw contact level
  output logic level_o      // Filtered level
);

  logic sync1_reg;
  logic sync2_reg;
  logic [fpm_pkg::CNT_W-1:0] cnt_reg;

  always_ff @(posedge mclk_i) begin
    sync1_reg <= raw_i;
    sync2_reg <= sync1_reg;
  end

  // ----------------------------------------
  // Filter: accept a level once it held long enough
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_reg <= '0;
      level_o <= 1'b0;
    end else if (sync2_reg == level_o) begin
      cnt_reg <= '0;
    end else if (cnt_reg == fpm_pkg::CNT_W'(STABLE_CYC - 1)) begin
      cnt_reg <= '0;
      level_o <= sync2_reg;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

/* File: verilog/fpm_front_panel.sv */
// Front-panel supervisor: mode switch, reset button, address switch,
// status LED, error latch and register port.
// Assumes panel inputs are asynchronous; fault and sequencer inputs are
// synchronous to mclk_i.
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module fpm_front_panel #(
  parameter int STARTUP_CYC = fpm_pkg::STARTUP_CYC,
  parameter int DEBOUNCE_CYC = fpm_pkg::DEBOUNCE_CYC
) (
  input wire logic mclk_i,             // System clock, 50 MHz
  input wire logic reset_i,            // Power-on reset, active high
  input wire logic mode_local_pin_i,   // Mode switch, 1 = local
  input wire logic reset_btn_pin_i,    // Reset button, 1 = pressed
  input wire logic [3:0] addr_sw_i,    // Rotary address switch
  input wire logic [3:0] fault_i,      // Fault event pulses
  input wire logic fw_busy_i,          // Firmware update in progress
  input wire logic cmd_done_i,         // Remote command finished
  input wire logic host_call_req_i,    // Local program asks for host
  input wire logic [7:0] reg_addr_i,   // Register byte address
  input wire logic [31:0] reg_wdata_i, // Register write data
  input wire logic reg_wr_i,           // Write strobe
  input wire logic reg_rd_i,           // Read strobe
  output logic [31:0] reg_rdata_o,     // Read data, cycle after strobe
  output logic irq_o,                  // Interrupt, level
  output logic [3:0] bus_addr_o,       // Latched bus address
  output logic ready_o,                // Unit available
  output logic local_mode_o,           // Local mode active
  output logic prog_start_o,           // Start auto-start program, pulse
  output logic cmd_start_o,            // Remote command start, pulse
  output logic [2:0] cmd_code_o,       // Remote command code
  output logic host_link_en_o,         // Host link usable
  output logic led_green_o,            // LED green element
  output logic led_red_o               // LED red element
);

  fpm_pkg::fpm_state_t state_reg;
  fpm_pkg::fpm_state_t state_next;
  logic mode_local;
  logic btn_pressed;
  logic mode_prev_reg;
  logic [fpm_pkg::CNT_W-1:0] start_cnt_reg;
  logic [3:0] addr_s1_reg;
  logic [3:0] addr_s2_reg;
  logic [fpm_pkg::ERR_W-1:0] err_reg;
  logic [fpm_pkg::IRQ_W-1:0] irq_stat_reg;
  logic [fpm_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [fpm_pkg::IRQ_W-1:0] irq_set;
  logic link_allow_reg;
  logic cmd_busy_reg;
  logic fw_busy_reg;
  logic run;
  logic enter_local;
  logic enter_remote;
  logic cmd_write;
  logic cmd_ok;
  logic [2:0] cmd_wcode;
  logic wr_err;
  logic wr_irq;
  logic wr_mask;
  logic wr_link;

  // ----------------------------------------
  // Panel input conditioning
  // ----------------------------------------
  fpm_debounce #(
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_mode_deb (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .raw_i(mode_local_pin_i),
    .level_o(mode_local)
  );

  fpm_debounce #(
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_btn_deb (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .raw_i(reset_btn_pin_i),
    .level_o(btn_pressed)
  );

  // Address switch synchroniser
  always_ff @(posedge mclk_i) begin
    addr_s1_reg <= addr_sw_i;
    addr_s2_reg <= addr_s1_reg;
  end

  // ----------------------------------------
  // Reset / start-up sequencing
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fpm_pkg::FPM_ST_HOLD: begin
        if (!btn_pressed) begin
          state_next = fpm_pkg::FPM_ST_STARTUP;
        end
      end
      fpm_pkg::FPM_ST_STARTUP: begin
        if (btn_pressed) begin
          state_next = fpm_pkg::FPM_ST_HOLD;
        end else if (start_cnt_reg == fpm_pkg::CNT_W'(STARTUP_CYC - 1)) begin
          state_next = fpm_pkg::FPM_ST_RUN;
        end
      end
      fpm_pkg::FPM_ST_RUN: begin
        if (btn_pressed) begin
          state_next = fpm_pkg::FPM_ST_HOLD;
        end
      end
      default: begin
        state_next = fpm_pkg::FPM_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= fpm_pkg::FPM_ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || state_reg != fpm_pkg::FPM_ST_STARTUP) begin
      start_cnt_reg <= '0;
    end else begin
      start_cnt_reg <= start_cnt_reg + 1'b1;
    end
  end

  assign run = (state_reg == fpm_pkg::FPM_ST_RUN);

  // Address taken once as reset ends, held through operation
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bus_addr_o <= fpm_pkg::ADDR_RST;
    end else if (state_reg == fpm_pkg::FPM_ST_HOLD
                 && state_next == fpm_pkg::FPM_ST_STARTUP) begin
      bus_addr_o <= addr_s2_reg;
    end
  end

  // ----------------------------------------
  // Mode control
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mode_prev_reg <= 1'b0;
    end else if (run) begin
      mode_prev_reg <= mode_local;
    end else begin
      mode_prev_reg <= 1'b0;
    end
  end

  // Local at the end of start-up counts as a switch to local
  assign enter_local = run && mode_local && !mode_prev_reg;
  assign enter_remote = run && !mode_local && mode_prev_reg;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      local_mode_o <= 1'b0;
      prog_start_o <= 1'b0;
    end else begin
      local_mode_o <= run && mode_local;
      prog_start_o <= enter_local;
    end
  end

  // Remote link whenever running; local only if software allows and program asks
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      host_link_en_o <= 1'b0;
    end else begin
      host_link_en_o <= run && (!mode_local
                        || (link_allow_reg && host_call_req_i));
    end
  end

  // ----------------------------------------
  // Remote commands
  // ----------------------------------------
  assign cmd_wcode = reg_wdata_i[2:0];
  assign cmd_write = reg_wr_i && reg_addr_i == fpm_pkg::OFS_CMD
                     && reg_wdata_i[fpm_pkg::CMD_GO_BIT];
  assign cmd_ok = cmd_write && run && !mode_local && !cmd_busy_reg
                  && !fw_busy_reg && cmd_wcode != fpm_pkg::FPM_CMD_NONE
                  && cmd_wcode <= fpm_pkg::FPM_CMD_TEST_RUN;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cmd_start_o <= 1'b0;
      cmd_code_o <= fpm_pkg::FPM_CMD_NONE;
      cmd_busy_reg <= 1'b0;
    end else begin
      cmd_start_o <= cmd_ok;
      if (cmd_ok) begin
        cmd_code_o <= cmd_wcode;
        cmd_busy_reg <= 1'b1;
      end else if (cmd_done_i || !run || mode_local) begin
        cmd_busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Error latch
  // ----------------------------------------
  assign wr_err = reg_wr_i && reg_addr_i == fpm_pkg::OFS_ERROR;

  // New faults win over any clear in the same cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      err_reg <= fpm_pkg::ERR_RST;
    end else if (btn_pressed) begin
      err_reg <= fault_i;
    end else begin
      err_reg <= (err_reg & ~(wr_err ? reg_wdata_i[fpm_pkg::ERR_W-1:0]
                 : fpm_pkg::ERR_RST)) | fault_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fw_busy_reg <= 1'b0;
    end else begin
      fw_busy_reg <= fw_busy_i;
    end
  end

  // ----------------------------------------
  // Status indicator and ready
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      led_green_o <= 1'b0;
      led_red_o <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      ready_o <= run && !fw_busy_reg;
      if (fw_busy_reg) begin
        led_green_o <= 1'b1;
        led_red_o <= 1'b1;
      end else if (err_reg != fpm_pkg::ERR_RST) begin
        led_green_o <= 1'b0;
        led_red_o <= 1'b1;
      end else begin
        led_green_o <= run;
        led_red_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_set[fpm_pkg::IRQ_LOCAL] = enter_local;
  assign irq_set[fpm_pkg::IRQ_REMOTE] = enter_remote;
  assign irq_set[fpm_pkg::IRQ_ERROR] = |fault_i;
  assign irq_set[fpm_pkg::IRQ_READY] = state_reg == fpm_pkg::FPM_ST_STARTUP
                                       && state_next == fpm_pkg::FPM_ST_RUN;
  assign irq_set[fpm_pkg::IRQ_REFUSED] = cmd_write && !cmd_ok;
  assign wr_irq = reg_wr_i && reg_addr_i == fpm_pkg::OFS_IRQ_STAT;
  assign wr_mask = reg_wr_i && reg_addr_i == fpm_pkg::OFS_IRQ_MASK;
  assign wr_link = reg_wr_i && reg_addr_i == fpm_pkg::OFS_LINK_CTRL;

  // Set wins over write-one-to-clear
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_stat_reg <= fpm_pkg::IRQ_RST;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_irq ? reg_wdata_i[fpm_pkg::IRQ_W-1:0]
                      : fpm_pkg::IRQ_RST)) | irq_set;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_mask_reg <= fpm_pkg::IRQ_RST;
      link_allow_reg <= 1'b0;
    end else begin
      if (wr_mask) begin
        irq_mask_reg <= reg_wdata_i[fpm_pkg::IRQ_W-1:0];
      end
      if (wr_link) begin
        link_allow_reg <= reg_wdata_i[0];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
      case (reg_addr_i)
        fpm_pkg::OFS_STATUS: begin
          reg_rdata_o[fpm_pkg::ST_LOCAL_BIT] <= local_mode_o;
          reg_rdata_o[fpm_pkg::ST_READY_BIT] <= ready_o;
          reg_rdata_o[fpm_pkg::ST_BUSY_BIT] <= fw_busy_reg;
          reg_rdata_o[fpm_pkg::ST_CMD_BUSY_BIT] <= cmd_busy_reg;
          reg_rdata_o[fpm_pkg::ST_ADDR_LSB +: 4] <= bus_addr_o;
        end
        fpm_pkg::OFS_ERROR: begin
          reg_rdata_o[fpm_pkg::ERR_W-1:0] <= err_reg;
        end
        fpm_pkg::OFS_CMD: begin
          reg_rdata_o[2:0] <= cmd_code_o;
        end
        fpm_pkg::OFS_IRQ_STAT: begin
          reg_rdata_o[fpm_pkg::IRQ_W-1:0] <= irq_stat_reg;
        end
        fpm_pkg::OFS_IRQ_MASK: begin
          reg_rdata_o[fpm_pkg::IRQ_W-1:0] <= irq_mask_reg;
        end
        fpm_pkg::OFS_LINK_CTRL: begin
          reg_rdata_o[0] <= link_allow_reg;
        end
        default: begin
          reg_rdata_o <= 32'h0000_0000;
        end
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule

/* File: verification/fpm_host_model.sv */
// Host-side executor of remote commands.
// Assumes start_i is a one-cycle pulse on mclk_i.
`timescale 1ns/1ps
module fpm_host_model (
  input wire logic mclk_i,  // Clock
  input wire logic reset_i, // Reset
  input wire logic start_i, // Command start
  output logic done_o       // Command done
);
  logic [3:0] cnt;
  logic act;
  logic slow;
  initial done_o = 1'b0;
  // Alternates a prompt and a slow answer
  always @(posedge mclk_i) begin
    if (reset_i) begin
      done_o <= 1'b0;
      act <= 1'b0;
      slow <= 1'b0;
      cnt <= 4'h0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        act <= 1'b1;
        slow <= !slow;
        cnt <= slow ? 4'h9 : 4'h1;
      end else if (act) begin
        if (cnt == 4'h0) begin
          done_o <= 1'b1;
          act <= 1'b0;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule

/* File: verification/fpm_front_panel_assertions.sv */
// Port checker for the front-panel block.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module fpm_front_panel_assertions #(
  parameter int STARTUP_CYC = 50,
  parameter int DEBOUNCE_CYC = 4
) (
  input wire logic mclk_i,             // Clock
  input wire logic reset_i,            // Reset
  input wire logic fw_busy_i,          // Fw busy
  input wire logic [7:0] reg_addr_i,   // Address
  input wire logic [31:0] reg_wdata_i, // Wdata
  input wire logic reg_wr_i,           // Write
  input wire logic reg_rd_i,           // Read
  input wire logic [31:0] reg_rdata_o, // Rdata
  input wire logic [3:0] bus_addr_o,   // Bus address
  input wire logic ready_o,            // Ready
  input wire logic local_mode_o,       // Local
  input wire logic prog_start_o,       // Program start
  input wire logic cmd_start_o,        // Cmd start
  input wire logic [2:0] cmd_code_o,   // Cmd code
  input wire logic led_green_o,        // Green
  input wire logic led_red_o           // Red
);
  int up_cnt;
  logic cmd_wr;
  logic [2:0] wcode;
  assign cmd_wr = reg_wr_i && reg_addr_i == fpm_pkg::OFS_CMD;
  assign wcode = reg_wdata_i[2:0];
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      up_cnt <= 0;
    end else if (up_cnt < STARTUP_CYC) begin
      up_cnt <= up_cnt + 1;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_cmd_go;
    cmd_wr ##1 cmd_start_o;
  endsequence
  sequence s_fw_held;
    fw_busy_i ##1 fw_busy_i;
  endsequence
  start_wait_a: assert property (ready_o |-> up_cnt >= STARTUP_CYC)
    else $error("ready before start-up delay");
  cmd_source_a: assert property (cmd_start_o |-> $past(cmd_wr))
    else $error("command start without write");
  cmd_code_a: assert property (cmd_start_o |-> cmd_code_o == $past(wcode))
    else $error("command code mismatch");
  cmd_pulse_a: assert property (s_cmd_go |=> !cmd_start_o)
    else $error("command start too long");
  fw_orange_a: assert property (s_fw_held |=> led_green_o && led_red_o && !ready_o)
    else $error("no orange during update");
  prog_local_a: assert property (prog_start_o |-> local_mode_o ##1 !prog_start_o)
    else $error("program start malformed");
  rd_quiet_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside slot");
  addr_frozen_a: assert property (ready_o |-> $stable(bus_addr_o))
    else $error("address moved while running");
  green_ready_a: assert property (led_green_o && !led_red_o |-> ready_o)
    else $error("green while not ready");
endmodule
bind fpm_front_panel fpm_front_panel_assertions #(
  .STARTUP_CYC(STARTUP_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)
) i_fpm_front_panel_assertions (
  .mclk_i, .reset_i, .fw_busy_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .bus_addr_o, .ready_o, .local_mode_o, .prog_start_o, .cmd_start_o,
  .cmd_code_o, .led_green_o, .led_red_o
);

/* File: verification/testbench.sv */
// Self-checking bench for the front-panel block.
// Assumes short start-up and debounce counts below.
`timescale 1ns/1ps
module testbench;
  localparam int SU = 50;
  localparam int DB = 4;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic mode_local_pin_i = 1'b0;
  logic reset_btn_pin_i = 1'b0;
  logic [3:0] addr_sw_i = 4'ha;
  logic [3:0] fault_i = 4'h0;
  logic fw_busy_i = 1'b0;
  logic cmd_done_i;
  logic host_call_req_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic irq_o, ready_o, local_mode_o, prog_start_o, cmd_start_o;
  logic host_link_en_o, led_green_o, led_red_o;
  logic [3:0] bus_addr_o;
  logic [2:0] cmd_code_o;
  logic [31:0] rd_val;
  int err_count = 0;
  int checked = 0;
  int i;
  int n;
  always #10 mclk_i = ~mclk_i;
  fpm_front_panel #(.STARTUP_CYC(SU), .DEBOUNCE_CYC(DB)) i_fpm_front_panel (
    .mclk_i, .reset_i, .mode_local_pin_i, .reset_btn_pin_i, .addr_sw_i, .fault_i,
    .fw_busy_i, .cmd_done_i, .host_call_req_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .irq_o, .bus_addr_o, .ready_o, .local_mode_o,
    .prog_start_o, .cmd_start_o, .cmd_code_o, .host_link_en_o, .led_green_o, .led_red_o
  );
  fpm_host_model i_fpm_host_model (
    .mclk_i, .reset_i, .start_i(cmd_start_o), .done_o(cmd_done_i)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    err_count++;
    conclude();
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1;
    rd_val = reg_rdata_o;
  endtask
  task automatic pulse_fault(input logic [3:0] f);
    @(posedge mclk_i);
    fault_i <= f;
    @(posedge mclk_i);
    fault_i <= 4'h0;
    step(3);
  endtask
  task automatic wait_ready();
    for (n = 0; n < 300 && ready_o !== 1'b1; n++) step(1);
    if (ready_o !== 1'b1) hang();
    chk(n >= SU, 1'b1);
  endtask
  task automatic t_startup();
    wait_ready();
    chk(bus_addr_o, 4'ha);
    chk({led_green_o, led_red_o}, 2'b10);
    chk(host_link_en_o, 1'b1);
    @(posedge mclk_i);
    addr_sw_i <= 4'h5;
    step(8);
    chk(bus_addr_o, 4'ha);
    rd(fpm_pkg::OFS_STATUS);
    chk(rd_val[7:0], 8'ha2);
  endtask
  task automatic t_cmds();
    for (int c = 1; c <= 4; c++) begin
      wr(fpm_pkg::OFS_CMD, 32'h80 | 32'(c));
      #1;
      chk({cmd_start_o, cmd_code_o}, {1'b1, 3'(c)});
      for (i = 0; i < 20; i++) begin
        rd(fpm_pkg::OFS_STATUS);
        if (rd_val[3] === 1'b0) break;
      end
      if (i == 20) hang();
    end
    wr(fpm_pkg::OFS_CMD, 32'h80);
    #1;
    chk(cmd_start_o, 1'b0);
    wr(fpm_pkg::OFS_CMD, 32'h87);
    #1;
    chk(cmd_start_o, 1'b0);
    rd(fpm_pkg::OFS_IRQ_STAT);
    chk(rd_val[4], 1'b1);
    wr(fpm_pkg::OFS_IRQ_STAT, 32'h1f);
    rd(fpm_pkg::OFS_IRQ_STAT);
    chk(rd_val, 32'h0);
  endtask
  task automatic t_fault();
    wr(fpm_pkg::OFS_IRQ_MASK, 32'h04);
    pulse_fault(4'h5);
    chk({irq_o, led_green_o, led_red_o}, 3'b101);
    rd(fpm_pkg::OFS_ERROR);
    chk(rd_val, 32'h5);
    wr(fpm_pkg::OFS_ERROR, 32'hf);
    wr(fpm_pkg::OFS_IRQ_STAT, 32'h04);
    step(3);
    chk({irq_o, led_green_o, led_red_o}, 3'b010);
    rd(8'h20);
    chk(rd_val, 32'h0);
  endtask
  task automatic t_button();
    wr(fpm_pkg::OFS_IRQ_MASK, 32'h0);
    pulse_fault(4'h8);
    chk({irq_o, led_red_o}, 2'b01);
    @(posedge mclk_i);
    reset_btn_pin_i <= 1'b1;
    addr_sw_i <= 4'h3;
    step(DB + 6);
    chk(ready_o, 1'b0);
    rd(fpm_pkg::OFS_ERROR);
    chk(rd_val, 32'h0);
    @(posedge mclk_i);
    reset_btn_pin_i <= 1'b0;
    wait_ready();
    chk(bus_addr_o, 4'h3);
  endtask
  task automatic t_local();
    @(posedge mclk_i);
    mode_local_pin_i <= 1'b1;
    @(posedge mclk_i);
    mode_local_pin_i <= 1'b0;
    step(DB + 6);
    chk({prog_start_o, local_mode_o}, 2'b00);
    @(posedge mclk_i);
    mode_local_pin_i <= 1'b1;
    host_call_req_i <= 1'b1;
    for (i = 0; i < 30 && prog_start_o !== 1'b1; i++) step(1);
    if (prog_start_o !== 1'b1) hang();
    chk(local_mode_o, 1'b1);
    step(1);
    chk({prog_start_o, host_link_en_o}, 2'b00);
    wr(fpm_pkg::OFS_LINK_CTRL, 32'h1);
    step(3);
    chk(host_link_en_o, 1'b1);
    wr(fpm_pkg::OFS_CMD, 32'h81);
    #1;
    chk(cmd_start_o, 1'b0);
    @(posedge mclk_i);
    mode_local_pin_i <= 1'b0;
    host_call_req_i <= 1'b0;
    step(DB + 8);
    chk(local_mode_o, 1'b0);
    rd(fpm_pkg::OFS_IRQ_STAT);
    chk(rd_val, 32'h1f);
  endtask
  task automatic t_fw();
    @(posedge mclk_i);
    fw_busy_i <= 1'b1;
    step(3);
    chk({led_green_o, led_red_o, ready_o}, 3'b110);
    @(posedge mclk_i);
    fw_busy_i <= 1'b0;
    step(3);
    chk(ready_o, 1'b1);
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    #1;
    chk({ready_o, prog_start_o, cmd_start_o, irq_o}, 4'h0);
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_startup();
    t_cmds();
    t_fault();
    t_button();
    t_local();
    t_fw();
    conclude();
  end
endmodule
